// ==== src/slm_led_drv.sv ====
// module: drives one two-colour led from a colour request
// assumes the colour request is synchronous to mclk
`timescale 1ns/100ps
module slm_led_drv
   import slm_pkg::*;
#(
   parameter slm_color_t first_color = slm_led_green
) (
   input wire logic mclk,
   input wire logic srst,
   slm_led_if.snk req,
   output logic led_a,
   output logic led_b
);
   always_ff @(posedge mclk) begin
      if (srst) begin
         led_a <= 1'b0;
         led_b <= 1'b0;
      end else begin
         led_a <= (req.color == first_color);
         led_b <= (req.color != slm_led_off) && (req.color != first_color);
      end
   end

   led_pins_a: assert property (@(posedge mclk) disable iff (srst)
      !(led_a && led_b))
      else $error("both led colours lit");
endmodule // slm_led_drv

// ==== src/slm_led_if.sv ====
// interface: colour request from the encoder to a two-colour led driver
// assumes one clock domain shared with the top module
`timescale 1ns/100ps
interface slm_led_if;
   slm_pkg::slm_color_t color;
   modport src (output color);
   modport snk (input color);
endinterface

// ==== src/slm_pkg.sv ====
// package: constants and types for the status led and configuration mode block
// assumes a 100 MHz system clock
package slm_pkg;
   localparam int unsigned clk_hz = 100000000;
   localparam int unsigned uart_max_baud = 115000;
   localparam int unsigned spi_max_hz = 1000000;
   // shortest legal bit times in cycles (least times round up)
   localparam int unsigned uart_bit_cyc = (clk_hz + uart_max_baud - 1) / uart_max_baud;
   localparam int unsigned spi_bit_cyc = (clk_hz + spi_max_hz - 1) / spi_max_hz;
   // configuration session timeout, in milliseconds and cycles
   localparam int unsigned cfg_timeout_ms = 100;
   localparam int unsigned cfg_timeout_cyc = cfg_timeout_ms * (clk_hz / 1000);
   // blink timing in milliseconds and cycles
   localparam int unsigned blink_ms = 500;
   localparam int unsigned blink_cyc = blink_ms * (clk_hz / 1000);
   localparam int unsigned flash_on_ms = 200;
   localparam int unsigned flash_cyc = flash_on_ms * (clk_hz / 1000);
   localparam int unsigned cnt_w = 32;
   // acyclic flashing pattern, one bit per flash slot
   localparam logic [7:0] acyclic_pat = 8'h29;

   typedef enum logic [1:0] {
      slm_boot_fw_wait,
      slm_boot_sw_wait,
      slm_fw_running
   } slm_boot_t;

   typedef enum logic [2:0] {
      slm_bus_running,
      slm_bus_wrong_cfg,
      slm_bus_stop,
      slm_bus_not_cfg,
      slm_bus_idle
   } slm_bus_t;

   typedef enum logic [1:0] {
      slm_led_off,
      slm_led_green,
      slm_led_yellow,
      slm_led_red
   } slm_color_t;
endpackage

// ==== src/slm_status.sv ====
// module: configuration mode, host traffic gate and status led encoding
// assumes host frame decoding and the diagnostic link decoder sit outside
//
// Notes on behaviour
// - diagnostic tool connection established enters configuration mode.
// - host modbus frames are served only outside configuration mode.
// - host link at most 115 kBaud uart or 1 MHz spi.
// - modbus frames always carry crc; in spi mode crc is optional for non-modbus frames.
// - protocol stack work takes priority over host requests.
// - system led steady green while firmware runs.
// - system led alternates green and yellow while waiting for firmware.
// - system led steady yellow while bootloader waits for software.
// - comm led green run, red wrong config, cyclic and acyclic red flashing.
`timescale 1ns/100ps
module slm_status
   import slm_pkg::*;
#(
   parameter int unsigned cfg_timeout = cfg_timeout_cyc,
   parameter int unsigned blink_len = blink_cyc,
   parameter int unsigned flash_len = flash_cyc
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic diag_req,
   input wire logic host_req,
   input wire logic host_is_spi,
   input wire logic host_crc_ok,
   input wire logic host_crc_present,
   input wire logic host_is_modbus,
   input wire logic [cnt_w-1:0] host_bit_cyc,
   input wire logic stack_busy,
   input wire slm_boot_t boot_state,
   input wire slm_bus_t bus_state,
   output logic config_mode,
   output logic host_grant,
   output logic host_reject,
   output logic rate_error,
   output logic system_status_led_green,
   output logic system_status_led_yellow,
   output logic board_mode_led_green,
   output logic board_mode_led_red
);
   logic [cnt_w-1:0] cfg_cnt;
   logic [cnt_w-1:0] blink_cnt;
   logic [cnt_w-1:0] flash_cnt;
   logic blink_phase;
   logic [2:0] flash_slot;
   logic pending;
   logic pend_ok;
   slm_led_if sys_req ();
   slm_led_if bus_req ();

   function automatic logic rate_ok(input logic spi, input logic [cnt_w-1:0] bc);
      rate_ok = spi ? (bc >= cnt_w'(spi_bit_cyc)) : (bc >= cnt_w'(uart_bit_cyc));
   endfunction

   // session: every diagnostic request re-arms the timeout
   always_ff @(posedge mclk) begin
      if (srst) begin
         config_mode <= 1'b0;
         cfg_cnt <= '0;
      end else if (diag_req) begin
         config_mode <= 1'b1;
         cfg_cnt <= cnt_w'(cfg_timeout);
      end else if (cfg_cnt > 1) begin
         cfg_cnt <= cfg_cnt - 1'b1;
      end else begin
         config_mode <= 1'b0;
         cfg_cnt <= '0;
      end
   end

   // host request waits while the stack is busy, so latency varies
   always_ff @(posedge mclk) begin
      if (srst) begin
         pending <= 1'b0;
         pend_ok <= 1'b0;
         host_grant <= 1'b0;
         host_reject <= 1'b0;
         rate_error <= 1'b0;
      end else begin
         host_grant <= 1'b0;
         host_reject <= 1'b0;
         rate_error <= 1'b0;
         if (host_req && !pending) begin
            pending <= 1'b1;
            // modbus needs crc; spi non-modbus may omit it
            pend_ok <= rate_ok(host_is_spi, host_bit_cyc)
               && (host_crc_ok || (host_is_spi && !host_is_modbus && !host_crc_present));
            rate_error <= !rate_ok(host_is_spi, host_bit_cyc);
         end else if (pending && !stack_busy) begin
            pending <= 1'b0;
            host_grant <= pend_ok && !config_mode;
            host_reject <= !pend_ok || config_mode;
         end
      end
   end

   // blink and flash timebases
   always_ff @(posedge mclk) begin
      if (srst) begin
         blink_cnt <= '0;
         blink_phase <= 1'b0;
         flash_cnt <= '0;
         flash_slot <= '0;
      end else begin
         if (blink_cnt >= cnt_w'(blink_len - 1)) begin
            blink_cnt <= '0;
            blink_phase <= !blink_phase;
         end else begin
            blink_cnt <= blink_cnt + 1'b1;
         end
         if (flash_cnt >= cnt_w'(flash_len - 1)) begin
            flash_cnt <= '0;
            flash_slot <= flash_slot + 1'b1;
         end else begin
            flash_cnt <= flash_cnt + 1'b1;
         end
      end
   end

   always_comb begin
      case (boot_state)
         slm_fw_running: sys_req.color = slm_led_green;
         slm_boot_fw_wait: sys_req.color = blink_phase ? slm_led_yellow : slm_led_green;
         slm_boot_sw_wait: sys_req.color = slm_led_yellow;
         default: sys_req.color = slm_led_off;
      endcase
   end

   always_comb begin
      case (bus_state)
         slm_bus_running: bus_req.color = slm_led_green;
         slm_bus_wrong_cfg: bus_req.color = slm_led_red;
         slm_bus_stop: bus_req.color = blink_phase ? slm_led_red : slm_led_off;
         slm_bus_not_cfg: bus_req.color = acyclic_pat[flash_slot] ? slm_led_red : slm_led_off;
         default: bus_req.color = slm_led_off;
      endcase
   end

   slm_led_drv #(.first_color(slm_led_green)) u_sys (
      .mclk(mclk),
      .srst(srst),
      .req(sys_req),
      .led_a(system_status_led_green),
      .led_b(system_status_led_yellow)
   );

   slm_led_drv #(.first_color(slm_led_green)) u_bus (
      .mclk(mclk),
      .srst(srst),
      .req(bus_req),
      .led_a(board_mode_led_green),
      .led_b(board_mode_led_red)
   );

   cfg_enter_a: assert property (@(posedge mclk) disable iff (srst)
      diag_req |=> config_mode)
      else $error("no configuration mode after tool request");
   cfg_drop_a: assert property (@(posedge mclk) disable iff (srst)
      (config_mode && !diag_req && cfg_cnt == 1) |=> !config_mode)
      else $error("configuration mode outlived timeout");
   cfg_hold_a: assert property (@(posedge mclk) disable iff (srst)
      (config_mode && !diag_req && cfg_cnt > 1) |=> config_mode)
      else $error("configuration mode dropped before timeout");
   cfg_block_a: assert property (@(posedge mclk) disable iff (srst)
      host_grant |-> !$past(config_mode))
      else $error("host served in configuration mode");
   serve_excl_a: assert property (@(posedge mclk) disable iff (srst)
      !(host_grant && host_reject))
      else $error("frame both served and refused");
   rate_chk_a: assert property (@(posedge mclk) disable iff (srst)
      (host_req && !pending && !host_is_spi && host_bit_cyc < cnt_w'(uart_bit_cyc))
      |=> rate_error)
      else $error("uart overspeed not flagged");
   rate_spi_a: assert property (@(posedge mclk) disable iff (srst)
      (host_req && !pending && host_is_spi && host_bit_cyc < cnt_w'(spi_bit_cyc))
      |=> rate_error)
      else $error("spi overspeed not flagged");
   rate_quiet_a: assert property (@(posedge mclk) disable iff (srst)
      (host_req && !pending && !host_is_spi && host_bit_cyc >= cnt_w'(uart_bit_cyc))
      |=> !rate_error)
      else $error("legal uart rate flagged");
   crc_need_a: assert property (@(posedge mclk) disable iff (srst)
      (host_req && !pending && host_is_modbus && !host_crc_ok) |=> !pend_ok)
      else $error("modbus frame without crc accepted");
   stack_pri_a: assert property (@(posedge mclk) disable iff (srst)
      stack_busy |=> !(host_grant || host_reject))
      else $error("host served while stack busy");
   stack_hold_a: assert property (@(posedge mclk) disable iff (srst)
      (pending && stack_busy) |=> pending)
      else $error("pending host request lost while stack busy");
   serve_pend_a: assert property (@(posedge mclk) disable iff (srst)
      (host_grant || host_reject) |-> $past(pending) && !$past(stack_busy))
      else $error("host answered without a pending request");
   // !srst in the antecedents: the led register still holds reset in the release cycle
   sys_run_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && boot_state == slm_fw_running) [*2]
      |-> system_status_led_green && !system_status_led_yellow)
      else $error("system led not green while running");
   sys_sw_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && boot_state == slm_boot_sw_wait) [*2] |-> system_status_led_yellow)
      else $error("system led not yellow waiting for software");
   sys_blink_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && boot_state == slm_boot_fw_wait) [*2]
      |-> system_status_led_green ^ system_status_led_yellow)
      else $error("system led dark while waiting for firmware");
   sys_alt_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && boot_state == slm_boot_fw_wait) [*2]
      |-> system_status_led_yellow == $past(blink_phase))
      else $error("system led not alternating while waiting for firmware");
   bus_wrong_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && bus_state == slm_bus_wrong_cfg) [*2]
      |-> board_mode_led_red && !board_mode_led_green)
      else $error("comm led not red on wrong configuration");
   bus_run_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && bus_state == slm_bus_running) [*2]
      |-> board_mode_led_green && !board_mode_led_red)
      else $error("comm led not green while running");
   bus_stop_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && bus_state == slm_bus_stop) [*2]
      |-> !board_mode_led_green && (board_mode_led_red == $past(blink_phase)))
      else $error("comm led not flashing cyclic red on stop");
   bus_acyc_a: assert property (@(posedge mclk) disable iff (srst)
      (!srst && bus_state == slm_bus_not_cfg) [*2]
      |-> !board_mode_led_green && (board_mode_led_red == acyclic_pat[$past(flash_slot)]))
      else $error("comm led not flashing acyclic red when not configured");
   led_off_a: assert property (@(posedge mclk)
      srst |=> !(system_status_led_green || system_status_led_yellow
         || board_mode_led_green || board_mode_led_red))
      else $error("led lit after reset");
endmodule // slm_status

// ==== testbench/slm_host_model.sv ====
// partner: host controller frames and diagnostic tool polls
// assumes the block samples these inputs on the rising edge of mclk
`timescale 1ns/100ps
module slm_host_model
   import slm_pkg::*;
(
   input wire logic mclk,
   output logic diag_req,
   output logic host_req,
   output logic host_is_spi,
   output logic host_crc_ok,
   output logic host_crc_present,
   output logic host_is_modbus,
   output logic [cnt_w-1:0] host_bit_cyc
);
   logic [cnt_w+3:0] attr;
   assign {host_is_spi, host_crc_present, host_crc_ok, host_is_modbus, host_bit_cyc} = attr;
   initial begin
      {diag_req, host_req} = 2'h0;
      attr = '1;
   end
   // kind: spi, crc present, crc good, modbus; attributes valid only with host_req
   task automatic send_frame(input logic [3:0] kind, input logic [cnt_w-1:0] bits);
      @(posedge mclk);
      host_req <= 1'b1;
      attr <= {kind, bits};
      @(posedge mclk);
      host_req <= 1'b0;
      attr <= ~{kind, bits};
   endtask
   task automatic poll(input int n, input int gap);
      repeat (n) begin
         @(posedge mclk);
         diag_req <= 1'b1;
         @(posedge mclk);
         diag_req <= 1'b0;
         repeat (gap) @(posedge mclk);
      end
   endtask
endmodule // slm_host_model

// ==== testbench/status_led_and_config_mode_bench.sv ====
// bench: host gating, configuration mode and led encoding
// assumes the partner model supplies host frames and tool polls
`timescale 1ns/100ps
module status_led_and_config_mode_bench;
   import slm_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, stack_busy = 1'b0;
   slm_boot_t boot_state = slm_fw_running;
   slm_bus_t bus_state = slm_bus_idle;
   logic diag_req, host_req, host_is_spi, host_crc_ok, host_crc_present, host_is_modbus;
   logic [cnt_w-1:0] host_bit_cyc;
   logic config_mode, host_grant, host_reject, rate_error, sys_g, sys_y, com_g, com_r;
   int n_errors = 0, checks = 0, cycles = 0;
   always #5 mclk = ~mclk;
   slm_host_model u_slm_host_model (.mclk(mclk), .diag_req(diag_req), .host_req(host_req),
      .host_is_spi(host_is_spi), .host_crc_ok(host_crc_ok), .host_crc_present(host_crc_present),
      .host_is_modbus(host_is_modbus), .host_bit_cyc(host_bit_cyc));
   slm_status #(.cfg_timeout(50), .blink_len(8), .flash_len(4)) u_slm_status (
      .mclk(mclk), .srst(srst), .diag_req(diag_req), .host_req(host_req),
      .host_is_spi(host_is_spi), .host_crc_ok(host_crc_ok), .host_crc_present(host_crc_present),
      .host_is_modbus(host_is_modbus), .host_bit_cyc(host_bit_cyc), .stack_busy(stack_busy),
      .boot_state(boot_state), .bus_state(bus_state), .config_mode(config_mode),
      .host_grant(host_grant), .host_reject(host_reject), .rate_error(rate_error),
      .system_status_led_green(sys_g), .system_status_led_yellow(sys_y),
      .board_mode_led_green(com_g), .board_mode_led_red(com_r));
   task automatic print_verdict();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   // bounded wait for the serve decision, noting any rate flag on the way
   task automatic frame_result(input logic exp_grant, input logic exp_rate);
      logic g, r, re;
      {g, r} = 2'h0;
      // rate flag stands only in the cycle after the request edge
      #1;
      re = (rate_error === 1'b1);
      for (int i = 0; i < 30 && !(g || r); i++) begin
         @(posedge mclk);
         #1;
         {g, r} = {host_grant, host_reject};
         re = re | (rate_error === 1'b1);
      end
      check(g, exp_grant);
      check(r, !exp_grant);
      check(re, exp_rate);
   endtask
   task automatic t_host();
      u_slm_host_model.send_frame(4'h7, uart_bit_cyc);
      frame_result(1, 0);
      u_slm_host_model.send_frame(4'h7, uart_bit_cyc - 1);
      frame_result(0, 1);
      u_slm_host_model.send_frame(4'hf, spi_bit_cyc - 1);
      frame_result(0, 1);
      u_slm_host_model.send_frame(4'h9, spi_bit_cyc);
      frame_result(0, 0);
      u_slm_host_model.send_frame(4'h8, spi_bit_cyc);
      frame_result(1, 0);
   endtask
   task automatic t_cfg();
      u_slm_host_model.poll(1, 0);
      @(posedge mclk);
      #1;
      check(config_mode, 1);
      u_slm_host_model.poll(4, 12);
      u_slm_host_model.send_frame(4'h7, uart_bit_cyc);
      frame_result(0, 0);
      repeat (60) @(posedge mclk);
      #1;
      check(config_mode, 0);
      u_slm_host_model.send_frame(4'h7, uart_bit_cyc);
      frame_result(1, 0);
   endtask
   task automatic t_stack();
      logic seen;
      seen = 1'b0;
      @(posedge mclk);
      stack_busy <= 1'b1;
      u_slm_host_model.send_frame(4'h7, uart_bit_cyc);
      repeat (10) begin
         @(posedge mclk);
         #1;
         seen = seen | (host_grant !== 1'b0) | (host_reject !== 1'b0);
      end
      check(seen, 0);
      @(posedge mclk);
      stack_busy <= 1'b0;
      frame_result(1, 0);
   endtask
   function automatic int lvl(input int c);
      return (c == 0) ? 0 : (c == 48) ? 1 : 2;
   endfunction
   // 0 never lit, 1 always lit, 2 lit part of the time
   task automatic t_leds();
      slm_boot_t bt[4] = '{slm_fw_running, slm_boot_sw_wait, slm_boot_fw_wait, slm_fw_running};
      slm_bus_t bs[4] = '{slm_bus_running, slm_bus_wrong_cfg, slm_bus_stop, slm_bus_not_cfg};
      int exp[4][4] = '{'{1, 0, 1, 0}, '{0, 1, 0, 1}, '{2, 2, 0, 2}, '{1, 0, 0, 2}};
      int n[4];
      logic [3:0] v;
      for (int s = 0; s < 4; s++) begin
         @(posedge mclk);
         boot_state <= bt[s];
         bus_state <= bs[s];
         repeat (3) @(posedge mclk);
         n = '{0, 0, 0, 0};
         repeat (48) begin
            @(posedge mclk);
            #1;
            v = {sys_g, sys_y, com_g, com_r};
            for (int k = 0; k < 4; k++) n[k] += (v[3-k] === 1'b1);
         end
         check(lvl(n[0]), exp[s][0]);
         check(lvl(n[1]), exp[s][1]);
         check(lvl(n[2]), exp[s][2]);
         check(lvl(n[3]), exp[s][3]);
         if (s == 2) check(n[0] + n[1], 48);
      end
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      #1;
      check({config_mode, host_grant, host_reject, rate_error, sys_g, sys_y, com_g, com_r}, 0);
      t_host();
      t_cfg();
      t_stack();
      t_leds();
      print_verdict();
   end
endmodule // status_led_and_config_mode_bench
